//--- rtl/ubec_device.sv
// Device end: endpoint registers, packet memory, transaction engine.
// Assumes a classic Wishbone master and the host end on the link.
// Contract
// - Hardware sets setup flag on correct SETUP
// - Setup flag writable only while reception flag clear
// - Receive handshake state toggles on written ones
// - Receive state: ignore, STALL, NAK, accept
// - Transmit state: ignore, STALL, NAK, send
// - Receive toggle tracks expected data PID
// - SETUP on control endpoint clears receive toggle
// - Toggle selects buffer; iso never flips; write-one flips
// - Reception flag set by hardware, cleared writing zero
// - Type codes: bulk, control, iso, interrupt
// - Kind means double buffer on bulk
// - Descriptor entry at base plus n times 8
// - Transmit start address in bits 15:1
// - Transmit count in bits 9:0
// - Double/iso transmit counts at 9:0, 25:16
// - Receive start address in bits 15:1
// - Receive count written with received bytes
// - Bus reset clears all but transfer flags
//
// The register addresses and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
module ubec_device
  import ubec_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq,
  ubec_link_if.dev_mp      link
);
  typedef enum logic [3:0] {S_IDLE = 4'h1, S_RX = 4'h2, S_TX = 4'h4, S_ACKW = 4'h8} ubec_state_t;
  ubec_state_t state;
  logic [15:0] ep_reg [NUM_EP];
  logic [31:0] mem [MEM_WORDS];
  logic [15:0] table_base;
  logic        force_rst;
  logic [2:0]  int_sts, int_mask;
  logic [2:0]  cur_ep, hit_idx;
  logic        cur_hit, hit, cur_acc, cur_buf1;
  ubec_tok_t   cur_kind;
  logic [15:0] ptr;
  logic [9:0]  cnt;
  logic        bus_rst, wb_go, wb_wr, sel_ep, sel_mem;
  logic [31:0] wmask, rdata;
  logic        dev_we;
  logic [7:0]  dev_idx;
  logic [31:0] dev_data, dev_mask;
  logic        ev_hit;
  logic [15:0] ev_set, ev_clr, ev_tog;
  logic [2:0]  ev_int;
  logic [2:0]  d_ep;
  logic [7:0]  desc_w;
  logic [15:0] e;
  logic        dbl, iso, ctl, take_tok, rx_buf1, tx_buf1;
  logic [31:0] w_txaddr, w_txcnt, w_rxaddr;
  logic [7:0]  mem_byte;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Bus waits while the engine writes memory, so no CPU write is lost
  assign bus_rst = link.bus_reset | force_rst;
  assign wb_go   = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~dev_we;
  assign wb_wr   = wb_go & wb_we_i;
  assign sel_ep  = (wb_adr_i[11:5] == 7'h00);
  assign sel_mem = (wb_adr_i[11:10] == MEM_WINDOW);
  assign wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  always_comb begin
    rdata = 32'h0000_0000;
    if (sel_ep) begin
      rdata[15:0] = ep_reg[wb_adr_i[4:2]];
    end else if (sel_mem) begin
      rdata = mem[wb_adr_i[9:2]];
    end else begin
      case (wb_adr_i)
        OFS_CTRL:     rdata[0] = force_rst;
        OFS_INT_STS:  rdata[2:0] = int_sts;
        OFS_INT_MASK: rdata[2:0] = int_mask;
        OFS_TABLE:    rdata[15:0] = table_base;
        default:      rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_go;
      wb_dat_o <= rdata;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      force_rst  <= 1'b0;
      table_base <= 16'h0000;
      int_mask   <= 3'h0;
    end else if (wb_wr && wb_sel_i[0]) begin
      if (wb_adr_i == OFS_CTRL) force_rst <= wb_dat_i[0];
      if (wb_adr_i == OFS_INT_MASK) int_mask <= wb_dat_i[2:0];
      if (wb_adr_i == OFS_TABLE && wb_sel_i[1]) table_base <= wb_dat_i[15:0] & TABLE_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  // A new event beats a clear in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      int_sts <= 3'h0;
      irq     <= 1'b0;
    end else begin
      int_sts <= (int_sts & ~((wb_wr && wb_sel_i[0] && wb_adr_i == OFS_INT_STS) ?
                 wb_dat_i[2:0] : 3'h0)) | ev_int;
      irq     <= |(int_sts & int_mask);
    end
  end

  // ----------------------------------------------------------------
  // Endpoint registers
  // ----------------------------------------------------------------
  for (genvar n = 0; n < NUM_EP; n++) begin : g_ep
    logic [15:0] wm, v;
    always_comb begin
      wm = (wb_wr && sel_ep && wb_adr_i[4:2] == 3'(n)) ? wmask[15:0] : 16'h0000;
      v  = (ep_reg[n] & ~(wm & EP_RW_MASK)) | (wb_dat_i[15:0] & wm & EP_RW_MASK);
      v  = v ^ (wb_dat_i[15:0] & wm & EP_TOG_MASK);
      v  = v & ~(~wb_dat_i[15:0] & wm & EP_W0C_MASK);
      if (wm[EP_SETUP] && !ep_reg[n][EP_CORRECT_RECEPTION_FLAG]) begin
        v[EP_SETUP] = wb_dat_i[EP_SETUP];
      end
      if (ev_hit && cur_ep == 3'(n)) begin
        v = ((v & ~ev_clr) | ev_set) ^ ev_tog;
      end
    end
    always_ff @(posedge clk) begin
      if (reset) begin
        ep_reg[n] <= EP_RESET;
      end else if (bus_rst) begin
        ep_reg[n] <= (ep_reg[n] & EP_KEEP) | (EP_RESET & ~EP_KEEP);
      end else begin
        ep_reg[n] <= v;
      end
    end
  end

  // ----------------------------------------------------------------
  // Descriptor lookup
  // ----------------------------------------------------------------
  always_comb begin
    hit     = 1'b0;
    hit_idx = 3'h0;
    for (int i = NUM_EP - 1; i >= 0; i--) begin
      if (ep_reg[i][3:0] == link.tok_ep) begin
        hit     = 1'b1;
        hit_idx = 3'(i);
      end
    end
  end

  assign take_tok = link.tok_valid && (state == S_IDLE || state == S_ACKW);
  assign d_ep     = take_tok ? hit_idx : cur_ep;
  assign e        = ep_reg[d_ep];
  assign desc_w   = table_base[8:1] + {3'h0, d_ep, 2'b00};
  assign w_txaddr = mem[desc_w + DESC_TXADDR];
  assign w_txcnt  = mem[desc_w + DESC_TXCNT];
  assign w_rxaddr = mem[desc_w + DESC_RXADDR];
  assign ctl      = (e[EP_TYPE +: 2] == TYPE_CTRL);
  assign iso      = (e[EP_TYPE +: 2] == TYPE_ISO);
  assign dbl      = (e[EP_TYPE +: 2] == TYPE_BULK) && e[EP_KIND];
  assign rx_buf1  = (dbl | iso) & e[EP_RXTOG];
  assign tx_buf1  = (dbl | iso) & e[EP_TXTOG];
  assign mem_byte = ptr[0] ? mem[ptr[8:1]][15:8] : mem[ptr[8:1]][7:0];

  // ----------------------------------------------------------------
  // Transaction engine
  // ----------------------------------------------------------------
  always_comb begin
    dev_we   = 1'b0;
    dev_idx  = ptr[8:1];
    dev_data = {16'h0000, link.dat_byte, link.dat_byte};
    dev_mask = ptr[0] ? 32'h0000_ff00 : 32'h0000_00ff;
    ev_hit   = 1'b0;
    ev_set   = 16'h0000;
    ev_clr   = 16'h0000;
    ev_tog   = 16'h0000;
    ev_int   = 3'h0;
    if (state == S_RX && cur_hit && cur_acc) begin
      if (link.dat_valid) begin
        dev_we = 1'b1;
      end else if (link.dat_end && link.dat_ok) begin
        ev_hit   = 1'b1;
        dev_idx  = desc_w + DESC_RXCNT;
        dev_data = {6'h00, cnt, 6'h00, cnt};
        dev_mask = cur_buf1 ? 32'h03ff_0000 : 32'h0000_03ff;
        if (cur_kind == TOK_SETUP && ctl) begin
          dev_we = 1'b1;
          ev_set = 16'h0001 << EP_CORRECT_RECEPTION_FLAG | 16'h0001 << EP_SETUP;
          ev_clr = 16'h0001 << EP_RXTOG;
          ev_int = 3'h1 << INT_RX | 3'h1 << INT_SETUP;
        end else if (iso || link.dat_pid == e[EP_RXTOG]) begin
          dev_we = 1'b1;
          ev_set = 16'h0001 << EP_CORRECT_RECEPTION_FLAG;
          ev_clr = 16'h0001 << EP_SETUP;
          ev_tog = iso ? 16'h0000 : 16'h0001 << EP_RXTOG;
          ev_int = 3'h1 << INT_RX;
        end
      end
    end
    if (state == S_ACKW && !take_tok && link.hs_valid && cur_hit) begin
      ev_hit = 1'b1;
      ev_set = 16'h0001 << EP_CORRECT_TRANSMISSION_FLAG;
      ev_tog = 16'h0001 << EP_TXTOG;
      ev_int = 3'h1 << INT_TX;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || bus_rst) begin
      state    <= S_IDLE;
      cur_ep   <= 3'h0;
      cur_hit  <= 1'b0;
      cur_acc  <= 1'b0;
      cur_buf1 <= 1'b0;
      cur_kind <= TOK_OUT;
      ptr      <= 16'h0000;
      cnt      <= 10'h000;
    end else if (take_tok) begin
      cur_ep   <= hit_idx;
      cur_hit  <= hit;
      cur_kind <= link.tok_kind;
      cur_acc  <= (link.tok_kind == TOK_SETUP && ctl) || e[EP_RX_HANDSHAKE_STATE +: 2] == HS_VALID;
      if (link.tok_kind == TOK_IN) begin
        cur_buf1 <= tx_buf1;
        ptr      <= {(tx_buf1 ? w_rxaddr[15:1] : w_txaddr[15:1]), 1'b0};
        cnt      <= tx_buf1 ? w_txcnt[CNT1_LSB +: 10] : w_txcnt[CNT0_LSB +: 10];
        state    <= (hit && e[EP_TX_HANDSHAKE_STATE +: 2] == HS_VALID) ? S_TX : S_IDLE;
      end else begin
        cur_buf1 <= rx_buf1;
        ptr      <= {(rx_buf1 ? w_txaddr[15:1] : w_rxaddr[15:1]), 1'b0};
        cnt      <= 10'h000;
        state    <= S_RX;
      end
    end else begin
      case (state)
        S_RX: begin
          if (dev_we && link.dat_valid) begin
            ptr <= ptr + 16'h0001;
            cnt <= cnt + 10'h001;
          end
          if (link.dat_end) state <= S_IDLE;
        end
        S_TX: begin
          if (cnt != 10'h000) begin
            ptr <= ptr + 16'h0001;
            cnt <= cnt - 10'h001;
          end else begin
            state <= iso ? S_IDLE : S_ACKW;
          end
        end
        S_ACKW: if (link.hs_valid) state <= S_IDLE;
        default: state <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Link outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      link.rsp_valid <= 1'b0;
      link.rsp_code  <= RSP_NONE;
      link.d_valid   <= 1'b0;
      link.d_byte    <= 8'h00;
      link.d_end     <= 1'b0;
      link.d_pid     <= 1'b0;
    end else begin
      link.rsp_valid <= 1'b0;
      link.d_valid   <= 1'b0;
      link.d_end     <= 1'b0;
      if (take_tok && link.tok_kind == TOK_IN) begin
        link.rsp_valid <= 1'b1;
        link.d_pid     <= iso ? 1'b0 : e[EP_TXTOG];
        case (hit ? e[EP_TX_HANDSHAKE_STATE +: 2] : HS_DIS)
          HS_STALL: link.rsp_code <= RSP_STALL;
          HS_NAK:   link.rsp_code <= RSP_NAK;
          HS_VALID: link.rsp_code <= RSP_DATA;
          default:  link.rsp_code <= RSP_NONE;
        endcase
      end else if (state == S_RX && link.dat_end && !bus_rst) begin
        link.rsp_valid <= 1'b1;
        if (!cur_hit || (cur_acc && (!link.dat_ok || iso))) begin
          link.rsp_code <= RSP_NONE;
        end else if (cur_acc) begin
          link.rsp_code <= RSP_ACK;
        end else begin
          case (e[EP_RX_HANDSHAKE_STATE +: 2])
            HS_STALL: link.rsp_code <= RSP_STALL;
            HS_NAK:   link.rsp_code <= RSP_NAK;
            default:  link.rsp_code <= RSP_NONE;
          endcase
        end
      end else if (state == S_TX && !bus_rst) begin
        link.d_valid <= (cnt != 10'h000);
        link.d_byte  <= mem_byte;
        link.d_end   <= (cnt == 10'h000);
      end
    end
  end

  // ----------------------------------------------------------------
  // Packet memory
  // ----------------------------------------------------------------
  // Engine writes win; the bus is held off in that cycle
  always_ff @(posedge clk) begin
    if (dev_we) begin
      mem[dev_idx] <= (mem[dev_idx] & ~dev_mask) | (dev_data & dev_mask);
    end else if (wb_wr && sel_mem) begin
      mem[wb_adr_i[9:2]] <= (mem[wb_adr_i[9:2]] & ~wmask) | (wb_dat_i & wmask);
    end
  end
endmodule

//--- rtl/ubec_pkg.sv
// Shared constants for the endpoint buffer control block and its link.
// Assumes one 250 MHz clock and synchronous active-high reset on both ends.
package ubec_pkg;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_EP    = 8;
  localparam int MEM_WORDS = 256;
  localparam int HBUF_LEN  = 64;
  // ----------------------------------------------------------------
  // Endpoint register fields
  // ----------------------------------------------------------------
  localparam int EP_TX_HANDSHAKE_STATE  = 4;
  localparam int EP_TXTOG  = 6;
  localparam int EP_CORRECT_TRANSMISSION_FLAG   = 7;
  localparam int EP_KIND   = 8;
  localparam int EP_TYPE   = 9;
  localparam int EP_SETUP  = 11;
  localparam int EP_RX_HANDSHAKE_STATE  = 12;
  localparam int EP_RXTOG  = 14;
  localparam int EP_CORRECT_RECEPTION_FLAG   = 15;
  localparam logic [15:0] EP_RESET    = 16'h0000;
  localparam logic [15:0] EP_KEEP     = 16'h8080;
  localparam logic [15:0] EP_RW_MASK  = 16'h070f;
  localparam logic [15:0] EP_TOG_MASK = 16'h7070;
  localparam logic [15:0] EP_W0C_MASK = 16'h8080;
  localparam logic [1:0] TYPE_BULK = 2'h0;
  localparam logic [1:0] TYPE_CTRL = 2'h1;
  localparam logic [1:0] TYPE_ISO  = 2'h2;
  localparam logic [1:0] TYPE_INT  = 2'h3;
  localparam logic [1:0] HS_DIS    = 2'h0;
  localparam logic [1:0] HS_STALL  = 2'h1;
  localparam logic [1:0] HS_NAK    = 2'h2;
  localparam logic [1:0] HS_VALID  = 2'h3;
  // ----------------------------------------------------------------
  // Bus map and descriptor layout
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL     = 12'h040;
  localparam logic [11:0] OFS_INT_STS  = 12'h044;
  localparam logic [11:0] OFS_INT_MASK = 12'h048;
  localparam logic [11:0] OFS_TABLE    = 12'h050;
  localparam logic [1:0]  MEM_WINDOW   = 2'h1;
  localparam logic [15:0] TABLE_MASK   = 16'hfff8;
  // Word offsets in an entry: local bytes 0, 2, 4 and 6
  localparam logic [7:0] DESC_TXADDR = 8'h00;
  localparam logic [7:0] DESC_TXCNT  = 8'h01;
  localparam logic [7:0] DESC_RXADDR = 8'h02;
  localparam logic [7:0] DESC_RXCNT  = 8'h03;
  localparam int CNT0_LSB = 0;
  localparam int CNT1_LSB = 16;
  localparam int INT_RX    = 0;
  localparam int INT_TX    = 1;
  localparam int INT_SETUP = 2;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int TIMEOUT_NS    = 1000;
  localparam int TIMEOUT_CYC   = TIMEOUT_NS / CLK_PERIOD_NS;
  typedef enum logic [1:0] {TOK_OUT = 2'h0, TOK_IN = 2'h1, TOK_SETUP = 2'h2} ubec_tok_t;
  typedef enum logic [2:0] {
    RSP_NONE = 3'h0, RSP_ACK = 3'h1, RSP_NAK = 3'h2, RSP_STALL = 3'h3, RSP_DATA = 3'h4
  } ubec_rsp_t;
endpackage

//--- rtl/ubec_link_if.sv
// Transaction-level bus link between host end and device end.
// Assumes both ends share clk; every signal is driven from a flip-flop.
`timescale 1ns/1ps
interface ubec_link_if;
  import ubec_pkg::*;
  logic       bus_reset;
  logic       tok_valid;
  ubec_tok_t  tok_kind;
  logic [3:0] tok_ep;
  logic       dat_valid;
  logic [7:0] dat_byte;
  logic       dat_end;
  logic       dat_ok;
  logic       dat_pid;
  logic       hs_valid;
  logic       rsp_valid;
  ubec_rsp_t  rsp_code;
  logic       d_valid;
  logic [7:0] d_byte;
  logic       d_end;
  logic       d_pid;
  modport dev_mp (
    input  bus_reset, tok_valid, tok_kind, tok_ep, dat_valid, dat_byte, dat_end,
    input  dat_ok, dat_pid, hs_valid,
    output rsp_valid, rsp_code, d_valid, d_byte, d_end, d_pid
  );
  modport host_mp (
    output bus_reset, tok_valid, tok_kind, tok_ep, dat_valid, dat_byte, dat_end,
    output dat_ok, dat_pid, hs_valid,
    input  rsp_valid, rsp_code, d_valid, d_byte, d_end, d_pid
  );
endinterface

//--- rtl/ubec_host.sv
// Host end: issues tokens and data on the link, collects answers.
// Assumes a user that loads the byte buffer before each command.
`timescale 1ns/1ps
module ubec_host
  import ubec_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       cmd_valid,
  input  ubec_tok_t       cmd_kind,
  input  wire logic [3:0] cmd_ep,
  input  wire logic       cmd_pid,
  input  wire logic [6:0] cmd_len,
  input  wire logic       cmd_iso,
  input  wire logic       cmd_corrupt,
  input  wire logic       bus_reset_req,
  input  wire logic       buf_we,
  input  wire logic [5:0] buf_addr,
  input  wire logic [7:0] buf_wdata,
  output logic            busy,
  output logic            done,
  output ubec_rsp_t       result,
  output logic      [6:0] in_len,
  output logic            in_pid,
  output logic      [7:0] buf_rdata,
  ubec_link_if.host_mp    link
);
  typedef enum logic [3:0] {H_IDLE = 4'h1, H_DATA = 4'h2, H_WAIT = 4'h4, H_IN = 4'h8} ubec_hstate_t;
  ubec_hstate_t state;
  logic [7:0]  hbuf [HBUF_LEN];
  logic [6:0]  idx, len;
  logic        iso, bad;
  logic [15:0] timer;

  // ----------------------------------------------------------------
  // Byte buffer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (state == H_IN && link.d_valid && idx < 7'(HBUF_LEN)) begin
      hbuf[idx[5:0]] <= link.d_byte;
    end else if (buf_we) begin
      hbuf[buf_addr] <= buf_wdata;
    end
    buf_rdata <= hbuf[buf_addr];
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Timeout covers a silent device; ignored requests come back as an RSP_NONE answer
  always_ff @(posedge clk) begin
    if (reset) begin
      state          <= H_IDLE;
      idx            <= 7'h00;
      len            <= 7'h00;
      iso            <= 1'b0;
      bad            <= 1'b0;
      timer          <= 16'h0000;
      busy           <= 1'b0;
      done           <= 1'b0;
      result         <= RSP_NONE;
      in_len         <= 7'h00;
      in_pid         <= 1'b0;
      link.bus_reset <= 1'b0;
      link.tok_valid <= 1'b0;
      link.tok_kind  <= TOK_OUT;
      link.tok_ep    <= 4'h0;
      link.dat_valid <= 1'b0;
      link.dat_byte  <= 8'h00;
      link.dat_end   <= 1'b0;
      link.dat_ok    <= 1'b0;
      link.dat_pid   <= 1'b0;
      link.hs_valid  <= 1'b0;
    end else begin
      link.bus_reset <= bus_reset_req;
      link.tok_valid <= 1'b0;
      link.dat_valid <= 1'b0;
      link.dat_end   <= 1'b0;
      link.hs_valid  <= 1'b0;
      done           <= 1'b0;
      case (state)
        H_IDLE: begin
          if (cmd_valid) begin
            link.tok_valid <= 1'b1;
            link.tok_kind  <= cmd_kind;
            link.tok_ep    <= cmd_ep;
            link.dat_pid   <= cmd_pid;
            len            <= cmd_len;
            iso            <= cmd_iso;
            bad            <= cmd_corrupt;
            idx            <= 7'h00;
            timer          <= 16'h0000;
            busy           <= 1'b1;
            state          <= (cmd_kind == TOK_IN) ? H_WAIT : H_DATA;
          end
        end
        H_DATA: begin
          if (idx < len) begin
            link.dat_valid <= 1'b1;
            link.dat_byte  <= hbuf[idx[5:0]];
            idx            <= idx + 7'h01;
          end else begin
            link.dat_end <= 1'b1;
            link.dat_ok  <= ~bad;
            state        <= H_WAIT;
          end
        end
        H_WAIT: begin
          timer <= timer + 16'h0001;
          if (link.rsp_valid && link.rsp_code == RSP_DATA) begin
            in_pid <= link.d_pid;
            idx    <= 7'h00;
            state  <= H_IN;
          end else if (link.rsp_valid || timer == 16'(TIMEOUT_CYC)) begin
            result <= link.rsp_valid ? link.rsp_code : RSP_NONE;
            done   <= 1'b1;
            busy   <= 1'b0;
            state  <= H_IDLE;
          end
        end
        H_IN: begin
          if (link.d_valid) idx <= idx + 7'h01;
          if (link.d_end) begin
            in_len        <= idx;
            link.hs_valid <= ~iso;
            result        <= RSP_DATA;
            done          <= 1'b1;
            busy          <= 1'b0;
            state         <= H_IDLE;
          end
        end
        default: state <= H_IDLE;
      endcase
    end
  end
endmodule

//--- tb/ubec_link_sva.sv
// Link checker: answer timing, data framing, bus reset.
// Assumes the signals of the one link joining both ends.
`timescale 1ns/1ps
module ubec_link_sva
  import ubec_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic bus_reset,
  input wire logic tok_valid,
  input ubec_tok_t tok_kind,
  input wire logic dat_end,
  input wire logic dat_ok,
  input wire logic rsp_valid,
  input ubec_rsp_t rsp_code,
  input wire logic d_valid,
  input wire logic d_end
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  AST_RSP_CAUSE: assert property (
    rsp_valid |-> $past(tok_valid) || $past(dat_end)) else $error("stray answer");
  AST_BAD_DATA: assert property (
    dat_end && !dat_ok |=> !rsp_valid || rsp_code == RSP_NONE) else $error("bad data answered");
  AST_ACK_CAUSE: assert property (
    rsp_valid && rsp_code == RSP_ACK |-> $past(dat_end) && $past(dat_ok)) else $error("lone ack");
  AST_DATA_IN: assert property (
    rsp_valid && rsp_code == RSP_DATA |-> $past(tok_kind) == TOK_IN) else $error("data not IN");
  AST_DATA_NEXT: assert property (
    rsp_valid && rsp_code == RSP_DATA |=> d_valid || d_end) else $error("data late");
  AST_END_ALONE: assert property (d_end |-> !d_valid) else $error("byte at end");
  AST_END_QUIET: assert property (d_end |=> !d_valid [*2]) else $error("byte after end");
  AST_BUS_RESET: assert property (
    bus_reset [*2] |-> !rsp_valid && !d_valid) else $error("answer in bus reset");
  cover property (rsp_valid && rsp_code == RSP_ACK);
  cover property (rsp_valid && rsp_code == RSP_STALL);
  cover property (d_end);
endmodule

//--- tb/tb_top.sv
// Bench: both ends on one link, driven over Wishbone and host commands.
// Assumes endpoint 1, table base 0, buffers at local byte 0x40.
`timescale 1ns/1ps
module tb_top;
  import ubec_pkg::*;
  logic        clk = 0, reset = 1, we = 0, cyc = 0, cv = 0, pid = 0, cor = 0, brq = 0;
  logic        bwe = 0, ack, irq, irqs, done, inp;
  logic [11:0] adr = 0;
  logic [31:0] wdat = 0, rd, wdo;
  logic [6:0]  len = 0, inl;
  logic [7:0]  bd = 0, brd;
  logic [5:0]  ba = 0;
  logic [1:0]  cur = 2'h3, x;
  ubec_tok_t   kind = TOK_OUT;
  ubec_rsp_t   res;
  ubec_rsp_t   ex[3] = '{RSP_NONE, RSP_STALL, RSP_NAK};
  int          n_errors = 0, compares = 0;
  ubec_link_if link();
  ubec_device ubec_device_i (.clk(clk), .reset(reset), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_we_i(we), .wb_sel_i(4'hf), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_dat_o(wdo),
    .wb_ack_o(ack), .irq(irq), .link(link));
  ubec_host ubec_host_i (.clk(clk), .reset(reset), .cmd_valid(cv), .cmd_kind(kind),
    .cmd_ep(4'h1), .cmd_pid(pid), .cmd_len(len), .cmd_iso(1'b0), .cmd_corrupt(cor),
    .bus_reset_req(brq), .buf_we(bwe), .buf_addr(ba), .buf_wdata(bd), .busy(),
    .done(done), .result(res), .in_len(inl), .in_pid(inp), .buf_rdata(brd), .link(link));
  ubec_link_sva ubec_link_sva_i (.clk(clk), .reset(reset), .bus_reset(link.bus_reset),
    .tok_valid(link.tok_valid), .tok_kind(link.tok_kind), .dat_end(link.dat_end),
    .dat_ok(link.dat_ok), .rsp_valid(link.rsp_valid), .rsp_code(link.rsp_code),
    .d_valid(link.d_valid), .d_end(link.d_end));
  initial forever #2 clk = ~clk;
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // Irq sampled with read data, clear of the edge race
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t = 0;
    {cyc, we, adr, wdat} <= {1'b1, w, a, d};
    do @(negedge clk); while (ack !== 1'b1 && ++t < 100);
    if (ack !== 1'b1) n_errors++;
    rd = wdo;
    irqs = irq;
    @(posedge clk);
    cyc <= 1'b0;
    @(posedge clk);
  endtask
  // Bound covers the host's own silent-endpoint timeout
  task automatic cmd(input ubec_tok_t k, input logic p, input logic [6:0] n, input logic c);
    int t = 0;
    kind <= k;
    {pid, len, cor, cv} <= {p, n, c, 1'b1};
    @(posedge clk);
    cv <= 1'b0;
    do @(negedge clk); while (done !== 1'b1 && ++t < 400);
    if (done !== 1'b1) n_errors++;
    @(posedge clk);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    wb(1, 12'h048, 32'h7);
    wb(1, 12'h410, 32'h40);
    wb(1, 12'h414, 32'h3);
    wb(1, 12'h418, 32'h40);
    wb(1, 12'h484, 32'h5a);
    wb(1, 12'h004, 32'h3031);
    {bwe, bd} <= {1'b1, 8'ha5};
    @(posedge clk);
    {ba, bd} <= {6'h1, 8'h3c};
    @(posedge clk);
    bwe <= 1'b0;
    cmd(TOK_OUT, 0, 2, 0);
    chk(res, RSP_ACK);
    wb(0, 12'h004, 0);
    chk(rd, 32'hf031);
    wb(0, 12'h41c, 0);
    chk(rd[9:0], 32'h2);
    wb(0, 12'h480, 0);
    chk(rd[15:0], 32'h3ca5);
    chk(irqs, 32'h1);
    wb(1, 12'h044, 32'h1);
    wb(0, 12'h044, 0);
    chk(irqs, 32'h0);
    wb(1, 12'h004, 32'h1);
    cmd(TOK_OUT, 1, 2, 1);
    chk(res, RSP_NONE);
    wb(0, 12'h004, 0);
    chk(rd, 32'h7031);
    $display("test receive done");
    for (int i = 0; i < 3; i++) begin
      x = cur ^ i[1:0];
      cur = i[1:0];
      wb(1, 12'h004, {16'h0, 2'h0, x, 6'h0, x, 4'h1});
      cmd(TOK_OUT, 1, 1, 0);
      chk(res, ex[i]);
      cmd(TOK_IN, 0, 0, 0);
      chk(res, ex[i]);
    end
    wb(1, 12'h004, 32'h1011);
    $display("test states done");
    wb(1, 12'h048, 32'h5);
    cmd(TOK_IN, 0, 0, 0);
    chk(res, RSP_DATA);
    chk(inl, 32'h3);
    chk(inp, 32'h0);
    ba <= 6'h2;
    @(posedge clk);
    @(negedge clk);
    chk(brd, 32'h5a);
    @(posedge clk);
    wb(0, 12'h044, 0);
    chk(rd, 32'h2);
    chk(irqs, 32'h0);
    wb(1, 12'h044, 32'h2);
    wb(0, 12'h004, 0);
    chk(rd, 32'h70f1);
    wb(1, 12'h414, 32'h00020003);
    wb(1, 12'h004, 32'h0101);
    cmd(TOK_IN, 0, 0, 0);
    chk(inl, 32'h2);
    chk(res, RSP_DATA);
    chk(inp, 32'h1);
    $display("test transmit done");
    wb(1, 12'h004, 32'h0201);
    cmd(TOK_SETUP, 0, 2, 0);
    chk(res, RSP_ACK);
    wb(1, 12'h004, 32'h8201);
    wb(0, 12'h004, 0);
    chk(rd, 32'hba31);
    brq <= 1'b1;
    repeat (4) @(posedge clk);
    brq <= 1'b0;
    repeat (3) @(posedge clk);
    wb(0, 12'h004, 0);
    chk(rd, 32'h8000);
    wb(0, 12'h0a0, 0);
    chk(rd, 32'h0);
    $display("test setup and reset done");
    report_and_stop;
  end
  initial begin
    #200000;
    n_errors++;
    report_and_stop;
  end
endmodule
